//--- shared/can_tx_rx_pkg.sv
// Constants, types and helpers for the CAN transmit/receive control block
// Assumes an 8-bit register port and an external CAN protocol engine
package can_tx_rx_pkg;

  localparam logic [15:0] TX_CTRL_ADDR = 16'hFFB1;
  localparam logic [15:0] RX_SUM_ADDR  = 16'hFFB2;
  localparam logic [7:0]  TX_CTRL_RST  = 8'h00;
  localparam logic [7:0]  RX_SUM_RST   = 8'h00;
  localparam logic [7:0]  UNMAPPED_RD  = 8'h00;
  localparam int          TXP_POS      = 7;
  localparam int          TXC_POS      = 4;
  localparam int          TXA_POS      = 2;
  localparam int          TXRQ_POS     = 0;
  localparam logic [3:0]  MASK0_BUF    = 4'h0;
  localparam logic [3:0]  MASK1_BUF    = 4'h2;

  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b00,
    TX_ARB  = 2'b01,
    TX_XMIT = 2'b11
  } tx_state_e;

  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } reg_req_s;

  typedef struct packed
  {
    logic ready;
    logic arbWon;
    logic arbLost;
    logic frameOk;
    logic frameErr;
  } eng_evt_s;

  typedef struct packed
  {
    logic       valid;
    logic [3:0] idx;
  } rx_evt_s;

  // One-hot select of the first eight receive buffers
  function automatic logic [7:0] rxSelect(input rx_evt_s e);
    logic [7:0] sel;
    sel = 8'h00;
    if (e.valid && (e.idx[3] == 1'b0))
    begin
      sel[e.idx[2:0]] = 1'b1;
    end
    return sel;
  endfunction

endpackage

//--- verilog/tx_buffer_slot.sv
// Request, abort and completion flags of one transmit buffer
// Assumes release pulses from the frame sequencer in the top module
`timescale 1ns/1ps
module tx_buffer_slot
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic initBit,
  input  wire logic wrReq,
  input  wire logic wrAbort,
  input  wire logic active,
  input  wire logic relDone,
  input  wire logic relOk,
  output wire logic reqBit,
  output wire logic abortBit,
  output wire logic doneBit
);

  logic req_ff;
  logic abort_ff;
  logic done_ff;
  logic nxt_req;
  logic nxt_abort;
  logic nxt_done;
  wire  preAbort = abort_ff && !active;
  wire  release_ = relDone || preAbort;

  assign nxt_req   = initBit ? 1'b0 : (wrReq || (req_ff && !release_));
  assign nxt_abort = initBit ? 1'b0 : (wrAbort || (abort_ff && !release_));
  assign nxt_done  = relDone ? relOk : (preAbort ? 1'b0 : done_ff);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_ff   <= 1'b0;
      abort_ff <= 1'b0;
      done_ff  <= 1'b0;
    end
    else
    begin
      req_ff   <= nxt_req;
      abort_ff <= nxt_abort;
      done_ff  <= nxt_done;
    end
  end

  assign reqBit   = req_ff;
  assign abortBit = abort_ff;
  assign doneBit  = done_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_req_set: assert property (wrReq && !initBit |=> req_ff)
    else $error("request write did not set request");
  a_req_hold: assert property (req_ff && !relDone && !preAbort && !initBit |=> req_ff)
    else $error("request cleared without completion");
  a_abort_with_req: assert property ($fell(req_ff) && !$past(wrAbort) |-> !abort_ff)
    else $error("abort not cleared with request");
  a_pre_abort: assert property (preAbort && !relDone && !wrReq && !initBit |=> !req_ff && !doneBit)
    else $error("early abort did not release with flag low");
  a_init_clear: assert property (initBit |=> !req_ff && !abort_ff)
    else $error("init did not clear request and abort");

endmodule

//--- verilog/can_tx_rx_control.sv
// Transmit arbitration, frame sequencing and receive summary of a CAN controller
// Assumes a protocol engine that reports arbitration and frame outcome as pulses
`timescale 1ns/1ps
module can_tx_rx_control
  import can_tx_rx_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire can_tx_rx_pkg::reg_req_s regReq,
  output wire logic [7:0]              rdData,
  input  wire logic                    initBit,
  input  wire logic [1:0]              maskCfg,
  input  wire can_tx_rx_pkg::eng_evt_s engEvt,
  output wire logic                    txStart,
  output wire logic                    txSel,
  input  wire can_tx_rx_pkg::rx_evt_s  rxStore,
  input  wire can_tx_rx_pkg::rx_evt_s  dnClear
);

  import can_tx_rx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  tx_state_e  state_ff;
  tx_state_e  nxt_state;
  logic       prio_ff;
  logic       nxt_prio;
  logic       sel_ff;
  logic       nxt_sel;
  logic       start_ff;
  logic       killed_ff;
  logic       nxt_killed;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  logic [7:0] rxSum_ff;
  logic [7:0] nxt_rxSum;
  logic [1:0] reqBits;
  logic [1:0] abortBits;
  logic [1:0] doneBits;
  logic [1:0] relDone;
  logic [1:0] relOk;

  wire       txCtrlHit = (regReq.addr == TX_CTRL_ADDR);
  wire       rxSumHit  = (regReq.addr == RX_SUM_ADDR);
  wire       txCtrlWr  = regReq.wr && txCtrlHit;
  wire [1:0] wrReq     = txCtrlWr ? regReq.data[TXRQ_POS +: 2] : 2'b00;
  wire [1:0] wrAbort   = txCtrlWr ? regReq.data[TXA_POS +: 2] : 2'b00;
  wire [7:0] txCtrlView = {prio_ff, 1'b0, doneBits, abortBits, reqBits};

  assign nxt_prio = txCtrlWr ? regReq.data[TXP_POS] : prio_ff;

  assign nxt_rdData = !regReq.rd ? rdData_ff :
                      txCtrlHit  ? txCtrlView :
                      rxSumHit   ? rxSum_ff :
                                   UNMAPPED_RD;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer selection
  wire [1:0] eligible  = reqBits & ~abortBits;
  wire       bothElig  = (eligible == 2'b11);
  wire       pickSel   = bothElig ? prio_ff : eligible[1];
  wire       startNow  = (state_ff == TX_IDLE) && engEvt.ready && (eligible != 2'b00) && !initBit;
  wire       abortCur  = sel_ff ? abortBits[1] : abortBits[0];
  wire       giveUp    = abortCur || killed_ff;
  wire       inArb     = (state_ff == TX_ARB);
  wire       inXmit    = (state_ff == TX_XMIT);
  wire       lostQuit  = inArb && engEvt.arbLost && giveUp;
  wire       errQuit   = inXmit && engEvt.frameErr && giveUp;
  wire       okDone    = inXmit && engEvt.frameOk;
  wire       relAny    = lostQuit || errQuit || okDone;
  wire       activeAny = (state_ff != TX_IDLE);

  assign relDone = relAny ? (sel_ff ? 2'b10 : 2'b01) : 2'b00;
  assign relOk   = {2{okDone}};
  assign nxt_sel = startNow ? pickSel : sel_ff;

  assign nxt_killed = (state_ff == TX_IDLE) ? 1'b0 : (killed_ff || initBit);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      TX_IDLE:
      begin
        if (startNow)
        begin
          nxt_state = TX_ARB;
        end
      end
      TX_ARB:
      begin
        if (engEvt.arbLost)
        begin
          nxt_state = TX_IDLE;
        end
        else if (engEvt.arbWon)
        begin
          nxt_state = TX_XMIT;
        end
      end
      TX_XMIT:
      begin
        if (engEvt.frameOk || engEvt.frameErr)
        begin
          nxt_state = TX_IDLE;
        end
      end
      default:
      begin
        nxt_state = TX_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive summary
  // Receive buffers that hold mask data instead of messages
  function automatic logic [7:0] maskedBufs(input logic [1:0] cfg);
    logic [7:0] m;
    m = 8'h00;
    if (cfg[0])
    begin
      m[MASK0_BUF[2:0]] = 1'b1;
    end
    if (cfg[1])
    begin
      m[MASK1_BUF[2:0]] = 1'b1;
    end
    return m;
  endfunction

  wire [7:0] maskBufs = maskedBufs(maskCfg);
  wire [7:0] rxSet    = rxSelect(rxStore) & ~maskBufs;
  wire [7:0] rxClr    = rxSelect(dnClear);

  assign nxt_rxSum = initBit ? RX_SUM_RST : (rxSet | (rxSum_ff & ~rxClr));

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff  <= TX_IDLE;
      prio_ff   <= TX_CTRL_RST[TXP_POS];
      sel_ff    <= 1'b0;
      start_ff  <= 1'b0;
      killed_ff <= 1'b0;
      rdData_ff <= TX_CTRL_RST;
      rxSum_ff  <= RX_SUM_RST;
    end
    else
    begin
      state_ff  <= nxt_state;
      prio_ff   <= nxt_prio;
      sel_ff    <= nxt_sel;
      start_ff  <= startNow;
      killed_ff <= nxt_killed;
      rdData_ff <= nxt_rdData;
      rxSum_ff  <= nxt_rxSum;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-buffer flags
  for (genvar b = 0; b < 2; b++)
  begin : g_slot
    tx_buffer_slot u_slot
    (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .initBit  (initBit),
      .wrReq    (wrReq[b]),
      .wrAbort  (wrAbort[b]),
      .active   (activeAny && (sel_ff == 1'(b))),
      .relDone  (relDone[b]),
      .relOk    (relOk[b]),
      .reqBit   (reqBits[b]),
      .abortBit (abortBits[b]),
      .doneBit  (doneBits[b])
    );
  end

  assign rdData  = rdData_ff;
  assign txStart = start_ff;
  assign txSel   = sel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_started;
    startNow ##1 txStart;
  endsequence

  sequence s_errNoQuit;
    inXmit && engEvt.frameErr && !engEvt.frameOk && !giveUp && !initBit && !txCtrlWr;
  endsequence

  a_prio_order: assert property (startNow && bothElig |=> txSel == $past(prio_ff))
    else $error("wrong buffer chosen with both pending");

  a_single_req: assert property (startNow && !bothElig |=> txSel == $past(eligible[1]))
    else $error("single request not chosen");

  a_start_pulse: assert property (s_started |=> !txStart && state_ff == TX_ARB)
    else $error("start pulse not single cycle");

  a_no_start_idle: assert property (txStart |-> $past(eligible) != 2'b00)
    else $error("frame started with no request");

  a_err_retry: assert property (s_errNoQuit |=> reqBits[$past(sel_ff)] ##0 state_ff == TX_IDLE)
    else $error("request lost after transmit error");

  a_frame_runs: assert property (inXmit && !engEvt.frameOk && !engEvt.frameErr |=> inXmit)
    else $error("frame cut short");

  a_lost_quit: assert property (lostQuit && !txCtrlWr && !initBit |=>
                                !reqBits[$past(sel_ff)] && !doneBits[$past(sel_ff)])
    else $error("aborted buffer retried after lost arbitration");

  a_err_quit: assert property (errQuit && !txCtrlWr && !initBit |=>
                               !reqBits[$past(sel_ff)] && !doneBits[$past(sel_ff)])
    else $error("aborted buffer retried after error");

  a_ok_done: assert property (okDone && !txCtrlWr && !initBit |=>
                              doneBits[$past(sel_ff)] && !reqBits[$past(sel_ff)])
    else $error("clean frame did not set completion");

  a_zero_keeps: assert property (txCtrlWr && !regReq.data[TXRQ_POS] && !relDone[0] && !activeAny
                                 && !abortBits[0] && !initBit |=> reqBits[0] == $past(reqBits[0]))
    else $error("zero write disturbed buffer 0");

  a_killed_noretry: assert property (inXmit && initBit |=> !reqBits[0] && !reqBits[1])
    else $error("init did not drop requests during frame");

  a_rx_set: assert property (rxSet != 8'h00 && !initBit |=> (rxSum_ff & $past(rxSet)) == $past(rxSet))
    else $error("stored message not flagged");

  a_rx_clear: assert property (dnClear.valid && !dnClear.idx[3] && !initBit
                               && !(rxStore.valid && rxStore.idx == dnClear.idx)
                               |=> !rxSum_ff[$past(dnClear.idx[2:0])])
    else $error("summary bit not cleared with new-data flag");

  a_rx_init: assert property (initBit |=> rxSum_ff == RX_SUM_RST)
    else $error("summary not cleared by init");

  a_mask_store: assert property (maskCfg[0] && !rxSum_ff[0] |=> !rxSum_ff[0])
    else $error("mask buffer 0 flagged a message");

  ////////////////////////////////////////////////////////////////////////////
  // Register view and flag history

  a_rd_ctrl: assert property (regReq.rd && txCtrlHit |=> rdData == $past(txCtrlView))
    else $error("control read returned wrong view");

  a_rd_sum: assert property (regReq.rd && rxSumHit |=> rdData == $past(rxSum_ff))
    else $error("summary read returned wrong view");

  a_rd_hold: assert property (!regReq.rd |=> $stable(rdData))
    else $error("read data moved without a read");

  a_sum_ro: assert property (regReq.wr && rxSumHit && !rxStore.valid && !dnClear.valid && !initBit
                             |=> $stable(rxSum_ff))
    else $error("write changed the summary");

  a_done_change: assert property ($changed(doneBits) |-> $past(relAny) || $past(abortBits != 2'b00))
    else $error("completion flag moved outside a release");

  a_req_fall0: assert property ($fell(reqBits[0]) |-> $past(relDone[0] || abortBits[0] || initBit))
    else $error("buffer 0 request cleared without completion");

  a_req_fall1: assert property ($fell(reqBits[1]) |-> $past(relDone[1] || abortBits[1] || initBit))
    else $error("buffer 1 request cleared without completion");

  a_abort_set: assert property (wrAbort != 2'b00 && !initBit
                                |=> (abortBits & $past(wrAbort)) == $past(wrAbort))
    else $error("abort write did not set abort");

  a_pick_clean: assert property (startNow |-> reqBits[pickSel] && !abortBits[pickSel])
    else $error("aborted or empty buffer started");

  a_start_arb: assert property (txStart |-> state_ff == TX_ARB)
    else $error("start pulse outside arbitration");

  a_prio_hold: assert property (!txCtrlWr |=> $stable(prio_ff))
    else $error("priority changed without a write");

  a_lost_retry: assert property (inArb && engEvt.arbLost && !giveUp && !txCtrlWr && !initBit
                                 |=> reqBits[$past(sel_ff)] && state_ff == TX_IDLE)
    else $error("request lost after lost arbitration");

  sequence s_killedErr;
    inXmit && killed_ff && engEvt.frameErr && !engEvt.frameOk && !txCtrlWr && !initBit;
  endsequence

  a_killed_done: assert property (s_killedErr |=>
                                  !reqBits[$past(sel_ff)] && !doneBits[$past(sel_ff)] && state_ff == TX_IDLE)
    else $error("killed frame retried after error");

  a_rx_high: assert property (rxStore.valid && rxStore.idx[3] && !dnClear.valid && !initBit
                              |=> $stable(rxSum_ff))
    else $error("high buffer index changed the summary");

  a_mask_store_hi: assert property (maskCfg[1] && !rxSum_ff[2] |=> !rxSum_ff[2])
    else $error("mask buffer 2 flagged a message");

endmodule

//--- tb/can_node_model.sv
// Behavioural protocol engine standing in for the other nodes on the bus
// Assumes txStart pulses from the control block; outcomes come DLY cycles apart
`timescale 1ns/1ps
module can_node_model
  import can_tx_rx_pkg::*;
#(
  parameter int DLY = 8
)
(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               rdy,
  input  wire logic               lose,
  input  wire logic               fail,
  input  wire logic               txStart,
  output can_tx_rx_pkg::eng_evt_s engEvt
);
  import can_tx_rx_pkg::*;

  int cnt;

  ////////////////////////////////////////////////////////////////
  // Arbitration then frame outcome; a started frame always ends
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      engEvt <= '0;
    end
    else
    begin
      engEvt <= '0;
      engEvt.ready <= rdy && (cnt == 0) && !txStart;
      if (txStart)
        cnt <= 1;
      else if (cnt == DLY && lose)
      begin
        engEvt.arbLost <= 1'b1;
        cnt <= 0;
      end
      else if (cnt == DLY)
      begin
        engEvt.arbWon <= 1'b1;
        cnt <= cnt + 1;
      end
      else if (cnt == 2 * DLY)
      begin
        engEvt.frameOk <= !fail;
        engEvt.frameErr <= fail;
        cnt <= 0;
      end
      else if (cnt != 0)
        cnt <= cnt + 1;
    end
  end
endmodule

//--- tb/can_tx_rx_control_bench.sv
// Self-checking bench for the CAN transmit/receive control block
// Assumes the behavioural engine model on the frame side
`timescale 1ns/1ps
module can_tx_rx_control_bench;
  import can_tx_rx_pkg::*;

  localparam logic [3:0] ABT [6] = '{4'h1, 4'h4, 4'h1, 4'h2, 4'h1, 4'h8};
  localparam logic [3:0] RXI [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};

  logic       mclk;
  logic       rst_n;
  logic       initBit;
  logic       rdy;
  logic       lose;
  logic       fail;
  logic [1:0] maskCfg;
  reg_req_s   regReq;
  rx_evt_s    rxStore;
  rx_evt_s    dnClear;
  eng_evt_s   engEvt;
  logic [7:0] rdData;
  logic [7:0] rv;
  logic       txStart;
  logic       txSel;
  int         nErrors;
  int         totalChecks;
  int         nStarts;

  can_tx_rx_control dut (.mclk(mclk), .rst_n(rst_n), .regReq(regReq), .rdData(rdData), .initBit(initBit),
    .maskCfg(maskCfg), .engEvt(engEvt), .txStart(txStart), .txSel(txSel), .rxStore(rxStore), .dnClear(dnClear));
  can_node_model node (.mclk(mclk), .rst_n(rst_n), .rdy(rdy), .lose(lose), .fail(fail), .txStart(txStart),
    .engEvt(engEvt));

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (txStart === 1'b1) nStarts++;

  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk) #1 regReq = '{1'b1, 1'b0, a, d};
    @(posedge mclk) #1 regReq = '0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge mclk) #1 regReq = '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) #1 regReq = '0;
    rv = rdData;
  endtask

  task automatic rxEv(input logic clr, input logic [3:0] idx);
    @(posedge mclk) #1;
    if (clr) dnClear = '{1'b1, idx};
    else rxStore = '{1'b1, idx};
    @(posedge mclk) #1 rxStore = '0;
    dnClear = '0;
  endtask

  task automatic waitStart(input logic exp);
    for (int i = 0; i < 60 && txStart !== 1'b1; i++) @(posedge mclk) #1;
    chk("txStart", {7'h00, txStart}, 8'h01);
    chk("txSel", {7'h00, txSel}, {7'h00, exp});
    @(posedge mclk) #1;
  endtask

  task automatic waitDone(input logic [7:0] exp);
    rv = 8'hFF;
    for (int i = 0; i < 40 && rv[1:0] !== 2'b00; i++) rd(TX_CTRL_ADDR);
    chk("tx_ctrl", rv, exp);
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic tReset;
    rd(TX_CTRL_ADDR);
    chk("tx_ctrl_rst", rv, 8'h00);
    rd(RX_SUM_ADDR);
    chk("rx_sum_rst", rv, 8'h00);
    rd(16'hFFB0);
    chk("unmapped", rv, 8'h00);
    $display("Test reset done");
  endtask

  task automatic tPriority;
    logic p;
    for (int k = 0; k < 2; k++)
    begin
      p = k[0];
      rdy = 0;
      wr(TX_CTRL_ADDR, {p, 7'h01});
      wr(TX_CTRL_ADDR, {p, 7'h02});
      rd(TX_CTRL_ADDR);
      chk("both_req", rv, {p, (k == 1) ? 7'h33 : 7'h03});
      rdy = 1;
      waitStart(p);
      waitStart(!p);
      waitDone({p, 7'h30});
    end
    $display("Test priority done");
  endtask

  task automatic tRetry;
    fail = 1;
    wr(TX_CTRL_ADDR, 8'h01);
    waitStart(0);
    for (int i = 0; i < 40 && engEvt.frameErr !== 1'b1; i++) @(posedge mclk) #1;
    fail = 0;
    rdy = 0;
    rd(TX_CTRL_ADDR);
    chk("req_after_err", rv, 8'h31);
    rdy = 1;
    waitStart(0);
    waitDone(8'h30);
    $display("Test retry done");
  endtask

  task automatic tAbort;
    logic pre;
    for (int k = 0; k < 6; k++)
    begin
      {pre, lose, fail} = ABT[k][3:1];
      rdy = !pre;
      wr(TX_CTRL_ADDR, 8'h01);
      if (!pre) waitStart(0);
      if (!pre && !lose) for (int i = 0; i < 40 && engEvt.arbWon !== 1'b1; i++) @(posedge mclk) #1;
      wr(TX_CTRL_ADDR, 8'h04);
      if (k == 2) rd(TX_CTRL_ADDR);
      if (k == 2) chk("abort_pending", rv, 8'h25);
      waitDone({3'b001, ABT[k][0], 4'h0});
    end
    lose = 0;
    fail = 0;
    $display("Test abort done");
  endtask

  task automatic tRxInit;
    int n;
    maskCfg = 2'b01;
    for (int k = 0; k < 5; k++) rxEv(0, RXI[k]);
    rd(RX_SUM_ADDR);
    chk("rx_sum_set", rv, 8'h0E);
    rxEv(1, 4'h1);
    wr(RX_SUM_ADDR, 8'hFF);
    rd(RX_SUM_ADDR);
    chk("rx_sum_clr", rv, 8'h0C);
    maskCfg = 2'b10;
    rxEv(1, 4'h2);
    rxEv(0, 4'h2);
    rd(RX_SUM_ADDR);
    chk("rx_sum_mask1", rv, 8'h08);
    rdy = 1;
    fail = 1;
    wr(TX_CTRL_ADDR, 8'h01);
    waitStart(0);
    initBit = 1;
    wr(TX_CTRL_ADDR, 8'h03);
    rd(TX_CTRL_ADDR);
    chk("init_tx_ctrl", rv, 8'h20);
    rd(RX_SUM_ADDR);
    chk("init_rx_sum", rv, 8'h00);
    initBit = 0;
    n = nStarts;
    repeat (40) @(posedge mclk) #1;
    chk("no_retransmit", nStarts[7:0], n[7:0]);
    $display("Test receive and init done");
  endtask

  task automatic final_report;
    $display("Checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    nErrors++;
    final_report;
  end

  initial
  begin
    mclk = 0;
    rst_n = 0;
    initBit = 0;
    rdy = 0;
    lose = 0;
    fail = 0;
    maskCfg = 2'b00;
    regReq = '0;
    rxStore = '0;
    dnClear = '0;
    repeat (5) @(posedge mclk);
    #1 rst_n = 1;
    tReset;
    tPriority;
    tRetry;
    tAbort;
    tRxInit;
    final_report;
  end
endmodule
